// [src/tccf_consts.svh]
`ifndef TCCF_CONSTS_SVH
`define TCCF_CONSTS_SVH
`define TCCF_ADDR_FLAGS 8'hC8
`define TCCF_ADDR_CMP0_HIGH 8'hC9
`define TCCF_ADDR_CMP1_HIGH 8'hCA
`define TCCF_FLAGS_RESET 8'h00
`define TCCF_FLAGS_MASK 8'h7F
`define TCCF_CMP_HIGH_RESET 8'h00
`define TCCF_BIT_EXT2_CAP0 0
`define TCCF_BIT_EXT3_CAP1 1
`define TCCF_BIT_EXT4_CAP2 2
`define TCCF_BIT_EXT5_CAP3 3
`define TCCF_BIT_CMP0 4
`define TCCF_BIT_CMP1 5
`define TCCF_BIT_CMP2 6
`define TCCF_PINS_SET_RESET 6
`define TCCF_PINS_TOGGLE 2
`define TCCF_PIN_RESET 8'h00
`endif

// [src/tccf_flags.sv]
// Overview of operation
// - Compare-2 match sets flag; gated by enable.
// - Compare-0 match sets flag; gated by enable.
// - Software-written ones interrupt too; software clears.
// - Channel-1 trigger set: capture event sets bit1.
// - No channel-1 trigger: bit1 is external interrupt 3.
// - Bit1 interrupts only with combined enable set.
// - Bit0 is capture-0 or external interrupt 2.
// - Bit3 is capture-3 or external interrupt 5.
// - Compare-0 value is high C9h, low A9h.
// - Compare-0 match sets enabled set/reset pins.
// - Compare-1 high byte at CAh, resets zero.
// - Compare-1 match clears enabled set/reset pins.
// - Compare-2 match toggles enabled toggle pins.
`timescale 1ns/10ps
`include "tccf_consts.svh"
module tccf_flags
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire tccf_pkg::tccf_byte_type sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output tccf_pkg::tccf_byte_type sfr_rdata,
  output logic sfr_hit,
  input wire tccf_pkg::tccf_word_type timer_value,
  input wire tccf_pkg::tccf_byte_type compare0_low_byte,
  input wire tccf_pkg::tccf_byte_type compare1_low_byte,
  input wire tccf_pkg::tccf_byte_type compare2_high_byte,
  input wire tccf_pkg::tccf_byte_type compare2_low_byte,
  input wire tccf_pkg::tccf_byte_type extended_irq_enable_reg,
  input wire tccf_pkg::tccf_byte_type capture_trigger_control,
  input wire tccf_pkg::tccf_byte_type pin_set_enable_reg,
  input wire tccf_pkg::tccf_byte_type pin_reset_enable_reg,
  input wire logic [3:0] capture_event,
  input wire logic [3:0] ext_irq_event,
  output logic [5:0] compare_set_reset_pin,
  output logic [1:0] compare_toggle_pin,
  output logic [6:0] irq_request
);
  import tccf_pkg::*;

  tccf_byte_type capture_compare_flags;
  tccf_byte_type compare0_high_byte;
  tccf_byte_type compare1_high_byte;
  tccf_byte_type next_flags;
  tccf_byte_type hw_set;
  tccf_word_type compare0_value;
  tccf_word_type compare1_value;
  tccf_word_type compare2_value;
  logic compare0_match;
  logic compare1_match;
  logic compare2_match;
  logic [3:0] capture_mode;
  logic [3:0] shared_event;
  logic wr_flags;
  logic wr_cmp0;
  logic wr_cmp1;
  logic [5:0] next_set_reset_pin;
  logic [1:0] next_toggle_pin;

  // The timer value is compared every cycle, so a match lasts as long as the timer
  // holds the matching count; the flag simply stays set in that time.
  assign compare0_value = {compare0_high_byte, compare0_low_byte};
  assign compare1_value = {compare1_high_byte, compare1_low_byte};
  assign compare2_value = {compare2_high_byte, compare2_low_byte};
  assign compare0_match = (timer_value == compare0_value);
  assign compare1_match = (timer_value == compare1_value);
  assign compare2_match = (timer_value == compare2_value);

  // Each channel's pair of trigger bits sits at control bits 2n and 2n+1.
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      assign capture_mode[ch] = |capture_trigger_control[2 * ch + 1 -: 2];
      assign shared_event[ch] = capture_mode[ch] ? capture_event[ch] : ext_irq_event[ch];
    end
  endgenerate

  assign hw_set = {1'b0, compare2_match, compare1_match, compare0_match, shared_event};
  assign wr_flags = sfr_wr && (sfr_addr == `TCCF_ADDR_FLAGS);
  assign wr_cmp0 = sfr_wr && (sfr_addr == `TCCF_ADDR_CMP0_HIGH);
  assign wr_cmp1 = sfr_wr && (sfr_addr == `TCCF_ADDR_CMP1_HIGH);
  // A write replaces the flags, so software can set or clear them, but a hardware
  // event in the same cycle is ORed in last so it is never lost.
  assign next_flags = ((wr_flags ? sfr_wdata : capture_compare_flags) | hw_set)
    & `TCCF_FLAGS_MASK;

  // Set and reset may hit one pin in the same cycle; reset is applied last and wins.
  assign next_set_reset_pin = (compare_set_reset_pin
    | (compare0_match ? pin_set_enable_reg[5:0] : 6'h00))
    & ~(compare1_match ? pin_reset_enable_reg[5:0] : 6'h00);
  assign next_toggle_pin = compare_toggle_pin
    ^ (compare2_match ? pin_reset_enable_reg[7:6] : 2'h0);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      capture_compare_flags <= `TCCF_FLAGS_RESET;
      compare0_high_byte <= `TCCF_CMP_HIGH_RESET;
      compare1_high_byte <= `TCCF_CMP_HIGH_RESET;
      compare_set_reset_pin <= 6'h00;
      compare_toggle_pin <= 2'h0;
    end
    else
    begin
      capture_compare_flags <= next_flags;
      if (wr_cmp0)
      begin
        compare0_high_byte <= sfr_wdata;
      end
      if (wr_cmp1)
      begin
        compare1_high_byte <= sfr_wdata;
      end
      compare_set_reset_pin <= next_set_reset_pin;
      compare_toggle_pin <= next_toggle_pin;
    end
  end

  // Every flag bit requests only through its own enable; bit 1 uses the shared enable.
  assign irq_request = capture_compare_flags[6:0] & extended_irq_enable_reg[6:0];

  // The reserved top bit reads as zero.
  assign sfr_hit = sfr_rd && ((sfr_addr == `TCCF_ADDR_FLAGS)
    || (sfr_addr == `TCCF_ADDR_CMP0_HIGH) || (sfr_addr == `TCCF_ADDR_CMP1_HIGH));
  assign sfr_rdata = (sfr_addr == `TCCF_ADDR_FLAGS) ? capture_compare_flags :
    (sfr_addr == `TCCF_ADDR_CMP0_HIGH) ? compare0_high_byte :
    (sfr_addr == `TCCF_ADDR_CMP1_HIGH) ? compare1_high_byte : 8'h00;

  a_cmp2_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    compare2_match |=> capture_compare_flags[6])
    else $error("compare-2 match did not set its flag");
  a_cmp0_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    (timer_value == {compare0_high_byte, compare0_low_byte}) |=> capture_compare_flags[4])
    else $error("compare-0 match did not set its flag");
  a_cmp1_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    compare1_match |=> capture_compare_flags[5])
    else $error("compare-1 match did not set its flag");
  a_sw_write_flag: assert property (@(posedge clk) disable iff (!nrst)
    wr_flags |=> (capture_compare_flags[6:0] & ~$past(hw_set[6:0]))
    == ($past(sfr_wdata[6:0]) & ~$past(hw_set[6:0])))
    else $error("software flag write not stored");
  a_flags_sticky: assert property (@(posedge clk) disable iff (!nrst)
    !wr_flags |=> (capture_compare_flags & $past(capture_compare_flags)) == $past(capture_compare_flags))
    else $error("hardware cleared a flag");
  a_cap1_event: assert property (@(posedge clk) disable iff (!nrst)
    (capture_trigger_control[3:2] != 2'h0 && capture_event[1]) |=> capture_compare_flags[1])
    else $error("capture-1 event lost");
  a_ext3_event: assert property (@(posedge clk) disable iff (!nrst)
    (capture_trigger_control[3:2] == 2'h0 && ext_irq_event[1]) |=> capture_compare_flags[1])
    else $error("external interrupt 3 event lost");
  a_ch1_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    irq_request[1] == (capture_compare_flags[1] && extended_irq_enable_reg[1]))
    else $error("bit 1 interrupt gating wrong");
  a_ch0_event: assert property (@(posedge clk) disable iff (!nrst)
    (capture_trigger_control[1:0] != 2'h0 ? capture_event[0] : ext_irq_event[0])
    |=> capture_compare_flags[0])
    else $error("bit 0 event lost");
  a_ch3_event: assert property (@(posedge clk) disable iff (!nrst)
    (capture_trigger_control[7:6] != 2'h0 ? capture_event[3] : ext_irq_event[3])
    |=> capture_compare_flags[3])
    else $error("bit 3 event lost");
  a_pin_set: assert property (@(posedge clk) disable iff (!nrst)
    (compare0_match && !compare1_match) |=>
    ((compare_set_reset_pin & $past(pin_set_enable_reg[5:0])) == $past(pin_set_enable_reg[5:0])))
    else $error("set-enabled pin not driven high");
  a_pin_reset: assert property (@(posedge clk) disable iff (!nrst)
    compare1_match |=> ((compare_set_reset_pin & $past(pin_reset_enable_reg[5:0])) == 6'h00))
    else $error("reset-enabled pin not driven low");
  a_pin_toggle: assert property (@(posedge clk) disable iff (!nrst)
    compare2_match |=> (compare_toggle_pin == ($past(compare_toggle_pin) ^ $past(pin_reset_enable_reg[7:6]))))
    else $error("toggle pin wrong after compare-2 match");
  a_cmp1_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmp1 |=> compare1_high_byte == $past(sfr_wdata))
    else $error("compare-1 high byte not written");
  // The high byte must land whole, or the 16-bit compare would match a mixed value.
  a_cmp0_write: assert property (@(posedge clk) disable iff (!nrst)
    wr_cmp0 |=> compare0_high_byte == $past(sfr_wdata))
    else $error("compare-0 high byte not written");
  a_top_bit_zero: assert property (@(posedge clk) disable iff (!nrst)
    capture_compare_flags[7] == 1'b0)
    else $error("reserved flag bit set");
  a_set_beats_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr_flags && compare2_match && !sfr_wdata[6]) |=> capture_compare_flags[6])
    else $error("hardware set lost to software clear");
endmodule

// [src/tccf_pkg.sv]
package tccf_pkg;
  typedef logic [7:0] tccf_byte_type;
  typedef logic [15:0] tccf_word_type;
endpackage

// [test/tccf_core_model.sv]
`timescale 1ns/10ps
module tccf_core_model
(
  input wire logic clk,
  output logic [7:0] addr,
  output tccf_pkg::tccf_byte_type wdata,
  output logic wr,
  output logic rd
);
  import tccf_pkg::*;
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One access per call; software clears flags by writing zero.
  task automatic put(input logic [7:0] a, input tccf_byte_type d, input logic w);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    // A released bus must not keep showing the last byte.
    wdata = ~d;
  endtask
endmodule

// [test/timer_capture_compare_flags_test.sv]
`timescale 1ns/10ps
module timer_capture_compare_flags_test;
  import tccf_pkg::*;
  logic clk, nrst, wr, rd, hit;
  logic [7:0] addr, regs[4] = '{8'hC8, 8'hC9, 8'hCA, 8'hC7};
  tccf_byte_type wdata, rdata, c0l, c1l, c2h, c2l, en, ctrl, sen, ren, h0, h1;
  tccf_word_type timer;
  logic [3:0] cap, ext;
  logic [5:0] srp;
  logic [1:0] tgp, irq_hi;
  logic [6:0] irq, ef;
  logic [7:0] ep, e;
  logic [23:0] notes[$];
  int fails = 0, tests_run = 0, seed = 31;
  tccf_core_model core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  tccf_flags dut (.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_rdata(rdata), .sfr_hit(hit), .timer_value(timer),
    .compare0_low_byte(c0l), .compare1_low_byte(c1l), .compare2_high_byte(c2h),
    .compare2_low_byte(c2l), .extended_irq_enable_reg(en),
    .capture_trigger_control(ctrl), .pin_set_enable_reg(sen),
    .pin_reset_enable_reg(ren), .capture_event(cap), .ext_irq_event(ext),
    .compare_set_reset_pin(srp), .compare_toggle_pin(tgp), .irq_request(irq));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    tests_run++;
    if (seen !== want)
    begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
    if (rd && notes.size() > 0)
    begin
      check({tgp, srp, 1'b0, irq, rdata}, notes.pop_front());
      check(hit, addr == 8'hC8 || addr == 8'hC9 || addr == 8'hCA);
    end
  task automatic rd_chk(input logic [7:0] a, input tccf_byte_type d);
    notes.push_back({ep, 1'b0, ef & en[6:0], d});
    core.put(a, 8'h00, 1'b0);
  endtask
  task automatic pulse(input logic [3:0] c, input logic [3:0] x, input tccf_word_type v);
    @(negedge clk);
    cap = c;
    ext = x;
    timer = v;
    @(negedge clk);
    cap = 4'h0;
    ext = 4'h0;
    timer = 16'h0000;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial
  begin
    {nrst, timer, cap, ext, ctrl, ef, ep} = '0;
    {c0l, c1l, c2l} = {8'h11, 8'h22, 8'h33};
    {c2h, en, sen, ren, h0, h1} = {$random(seed), $random(seed)};
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 8'h00);
    core.put(8'hC9, h0, 1'b1);
    core.put(8'hCA, h1, 1'b1);
    core.put(8'hC7, 8'hFF, 1'b1);
    foreach (regs[i]) rd_chk(regs[i], i == 1 ? h0 : i == 2 ? h1 : 8'h00);
    core.put(8'hC8, 8'hFF, 1'b1);
    ef = 7'h7F;
    rd_chk(8'hC8, 8'h7F);
    core.put(8'hC8, 8'h00, 1'b1);
    ef = 7'h00;
    // Only the low byte differs, so the low byte must take part in the match.
    pulse(4'h0, 4'h0, {h0, 8'h10});
    rd_chk(8'hC8, 8'h00);
    pulse(4'h0, 4'h0, {h0, c0l});
    {ef[4], ep[5:0]} = {1'b1, ep[5:0] | sen[5:0]};
    rd_chk(8'hC8, {1'b0, ef});
    pulse(4'h0, 4'h0, {h1, c1l});
    {ef[5], ep[5:0]} = {1'b1, ep[5:0] & ~ren[5:0]};
    rd_chk(8'hC8, {1'b0, ef});
    pulse(4'h0, 4'h0, {c2h, c2l});
    {ef[6], ep[7:6]} = {1'b1, ep[7:6] ^ ren[7:6]};
    rd_chk(8'hC8, {1'b0, ef});
    for (int ch = 0; ch < 4; ch++)
      for (int m = 0; m < 2; m++)
      begin
        core.put(8'hC8, 8'h00, 1'b1);
        {ef, e} = {7'h00, 8'h01 << ch};
        ctrl = m ? 8'h01 << (2 * ch + ($random(seed) & 1)) : 8'h00;
        en = $random(seed);
        pulse(m ? 4'h0 : e[3:0], m ? e[3:0] : 4'h0, 16'h0000);
        rd_chk(8'hC8, 8'h00);
        pulse(m ? e[3:0] : 4'h0, m ? 4'h0 : e[3:0], 16'h0000);
        ef = e[6:0];
        rd_chk(8'hC8, e);
      end
    ctrl = 8'h00;
    // A clear landing with an event must not lose the event.
    fork
      core.put(8'hC8, 8'h00, 1'b1);
      pulse(4'h0, 4'h4, 16'h0000);
    join
    ef = 7'h04;
    rd_chk(8'hC8, 8'h04);
    stop_test();
  end
endmodule
